// File: design/twnvm_master.sv
`timescale 1ns/10ps
module twnvm_fifo import twnvm_pkg::*; #(
  parameter int W = CMD_W,
  parameter int D = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // pointers wrap freely, so D must be a power of two
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

module twnvm_master import twnvm_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  twnvm_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [BYTE_W-1:0] cmd_byte,
  output logic rsp_valid,
  output logic [BYTE_W-1:0] rsp_byte,
  output logic rsp_ack,
  output logic busy
);
  typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BYTE} twnvm_mst_t;

  twnvm_mst_t st_q;
  twnvm_op_t op_q;
  twnvm_op_t f_op;
  logic f_valid;
  logic f_ready;
  logic [CMD_W-1:0] f_data;
  logic sda_f;
  logic tick;
  logic [DIV_W-1:0] div_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [BYTE_W-1:0] byte_q;
  logic [BYTE_W-1:0] sh_q;
  logic [BYTE_W-1:0] rx_q;
  logic scl_q;
  logic oe_n_q;

  twnvm_fifo #(.W(CMD_W), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data({cmd_op, cmd_byte}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  twnvm_sync #(.W(1), .INIT(1'h1)) u_sda (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(bus.sda),
    .q(sda_f)
  );

  // the engine takes a command only when idle, so a slow bus fills the fifo
  assign f_ready = st_q == M_IDLE;
  assign f_op = twnvm_op_t'(f_data[CMD_W-1:BYTE_W]);
  assign tick = (st_q != M_IDLE) && (div_q == DIV_LAST);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q <= DIV_ZERO;
      qtr_q <= QTR_0;
    end else if (st_q == M_IDLE) begin
      div_q <= DIV_ZERO;
      qtr_q <= QTR_0;
    end else if (tick) begin
      div_q <= DIV_ZERO;
      qtr_q <= qtr_q + 2'h1;
    end else begin
      div_q <= div_q + DIV_ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= M_IDLE;
      op_q <= OP_START;
      bit_q <= CNT_ZERO;
      byte_q <= '0;
      sh_q <= '0;
      rx_q <= '0;
      scl_q <= 1'h1;
      oe_n_q <= 1'h1;
      rsp_valid <= 1'h0;
      rsp_byte <= '0;
      rsp_ack <= 1'h0;
    end else begin
      rsp_valid <= 1'h0;
      case (st_q)
        M_IDLE: begin
          if (f_valid) begin
            op_q <= f_op;
            byte_q <= f_data[BYTE_W-1:0];
            sh_q <= f_data[BYTE_W-1:0];
            bit_q <= CNT_ZERO;
            case (f_op)
              OP_START: begin
                st_q <= M_START;
                oe_n_q <= 1'h1;
              end
              OP_STOP: begin
                st_q <= M_STOP;
                oe_n_q <= 1'h0;
              end
              OP_WRITE: begin
                st_q <= M_BYTE;
                oe_n_q <= f_data[MSB];
              end
              default: begin
                st_q <= M_BYTE;
                oe_n_q <= 1'h1;
              end
            endcase
          end
        end
        M_START: begin
          if (tick) begin
            case (qtr_q)
              QTR_0: scl_q <= 1'h1;
              QTR_1: oe_n_q <= 1'h0;
              QTR_2: scl_q <= 1'h0;
              default: st_q <= M_IDLE;
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            case (qtr_q)
              QTR_0: scl_q <= 1'h1;
              QTR_1: oe_n_q <= 1'h1;
              QTR_2: scl_q <= 1'h1;
              default: st_q <= M_IDLE;
            endcase
          end
        end
        M_BYTE: begin
          if (tick) begin
            case (qtr_q)
              QTR_0: scl_q <= 1'h1;
              QTR_2: begin
                if (bit_q != CNT_ACK) begin
                  rx_q <= {rx_q[NXT:0], sda_f};
                end else if (op_q == OP_WRITE) begin
                  rsp_ack <= ~sda_f;
                end else begin
                  rsp_ack <= ~byte_q[NACK_POS];
                end
              end
              QTR_3: begin
                scl_q <= 1'h0;
                if (bit_q == CNT_ACK) begin
                  st_q <= M_IDLE;
                  oe_n_q <= 1'h1;
                  rsp_valid <= 1'h1;
                  rsp_byte <= rx_q;
                end else begin
                  bit_q <= bit_q + CNT_ONE;
                  sh_q <= {sh_q[NXT:0], 1'h0};
                  if (bit_q == CNT_LAST) begin
                    // last read byte: release instead of acknowledging
                    oe_n_q <= (op_q == OP_WRITE) | byte_q[NACK_POS];
                  end else begin
                    oe_n_q <= (op_q != OP_WRITE) | sh_q[NXT];
                  end
                end
              end
              default: scl_q <= 1'h1;
            endcase
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  // a start or stop is only issued between bytes, never mid-byte
  assign bus.scl = scl_q;
  assign bus.m_sda_o = 1'h0;
  assign bus.m_sda_oe_n = oe_n_q;
  assign busy = st_q != M_IDLE;
endmodule

// File: design/twnvm_pkg.sv
package twnvm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_QTR_NS = 250;
  // least time: round up to whole cycles
  localparam int QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QTR_CYC - 1);
  localparam int ADDR_W = 11;
  localparam int PAGE_W = 3;
  localparam int BYTE_W = 8;
  localparam int MEM_DEPTH = 2048;
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 4;
  localparam int PAGE_HI = 3;
  localparam int PAGE_LO = 1;
  localparam int RW_POS = 0;
  localparam int NACK_POS = 0;
  localparam int MSB = 7;
  localparam int NXT = 6;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
  localparam int FIFO_DEPTH = 8;
  localparam int CMD_W = 10;
  localparam logic [1:0] QTR_0 = 2'h0;
  localparam logic [1:0] QTR_1 = 2'h1;
  localparam logic [1:0] QTR_2 = 2'h2;
  localparam logic [1:0] QTR_3 = 2'h3;
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} twnvm_op_t;
endpackage

// File: design/twnvm_if.sv
`timescale 1ns/10ps
interface twnvm_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic sda;
  // wired-and with a pull-up: a released driver leaves the line high
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);
  modport master(output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport slave(input scl, input sda, output s_sda_o, output s_sda_oe_n);
endinterface

// File: design/twnvm_slave.sv
`timescale 1ns/10ps
module twnvm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // s1_q feeds only s2_q; a bit moves once s2_q and s3_q agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (s2_q & s3_q) | (q & (s2_q | s3_q));
    end
  end
endmodule

module twnvm_slave import twnvm_pkg::*; #(
  parameter logic [3:0] DEV_TYPE = 4'h6 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  twnvm_if.slave bus,
  input wire logic wp,
  output logic [ADDR_W-1:0] cur_addr,
  output logic selected
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WORD, S_WDATA, S_RDATA, S_IGNORE} twnvm_sst_t;

  twnvm_sst_t st_q;
  logic [1:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic wp_f;
  logic scl_p_q;
  logic sda_p_q;
  logic [3:0] cnt_q;
  logic ackph_q;
  logic ackok_q;
  logic rw_q;
  logic [PAGE_W-1:0] page_q;
  logic [BYTE_W-1:0] rx_q;
  logic [BYTE_W-1:0] tx_q;
  logic [ADDR_W-1:0] addr_q;
  logic oe_n_q;
  logic [BYTE_W-1:0] mem_q [MEM_DEPTH];
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic active;
  logic [BYTE_W-1:0] byte_in;
  logic byte_done;
  logic ack_beg;
  logic ack_end;
  logic m_nack;
  logic to_read;
  logic wr_commit;
  logic rd_inc;
  logic hit;

  twnvm_sync #(.W(2), .INIT(2'h3)) u_pins (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({bus.scl, bus.sda}),
    .q(pins_f)
  );

  // protect pin is pulled down, so it resets unprotected
  twnvm_sync #(.W(1), .INIT(1'h0)) u_wp (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(wp),
    .q(wp_f)
  );

  assign scl_f = pins_f[1];
  assign sda_f = pins_f[0];
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign active = (st_q != S_IDLE) && (st_q != S_IGNORE);
  assign byte_in = {rx_q[NXT:0], sda_f};
  assign byte_done = active & scl_rise & ~ackph_q & (cnt_q == CNT_LAST);
  assign ack_beg = active & scl_fall & ~ackph_q & (cnt_q == CNT_ACK);
  assign ack_end = active & scl_fall & ackph_q;
  assign m_nack = (st_q == S_RDATA) & scl_rise & ackph_q & sda_f;
  assign to_read = ((st_q == S_ADDR) & ackok_q & rw_q) | (st_q == S_RDATA);
  assign wr_commit = byte_done & (st_q == S_WDATA) & ~wp_f;
  assign rd_inc = byte_done & (st_q == S_RDATA);
  assign hit = byte_in[TYPE_HI:TYPE_LO] == DEV_TYPE;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      cnt_q <= CNT_ZERO;
      ackph_q <= 1'h0;
      ackok_q <= 1'h0;
      rw_q <= 1'h0;
      page_q <= '0;
      rx_q <= '0;
    end else if (start) begin
      // a partial byte is simply dropped, memory untouched
      st_q <= S_ADDR;
      cnt_q <= CNT_ZERO;
      ackph_q <= 1'h0;
    end else if (stop) begin
      st_q <= S_IDLE;
      cnt_q <= CNT_ZERO;
      ackph_q <= 1'h0;
    end else if (active) begin
      if (scl_rise & ~ackph_q & (cnt_q != CNT_ACK)) begin
        rx_q <= byte_in;
        cnt_q <= cnt_q + CNT_ONE;
      end
      if (byte_done) begin
        case (st_q)
          S_ADDR: begin
            ackok_q <= hit;
            rw_q <= byte_in[RW_POS];
            page_q <= byte_in[PAGE_HI:PAGE_LO];
          end
          S_WORD: ackok_q <= 1'h1;
          S_WDATA: ackok_q <= ~wp_f;
          default: ackok_q <= 1'h0;
        endcase
      end
      if (ack_beg) begin
        ackph_q <= 1'h1;
      end
      if (m_nack) begin
        st_q <= S_IGNORE;
      end
      if (ack_end) begin
        ackph_q <= 1'h0;
        cnt_q <= CNT_ZERO;
        case (st_q)
          S_ADDR: begin
            if (!ackok_q) begin
              st_q <= S_IGNORE;
            end else if (rw_q) begin
              st_q <= S_RDATA;
            end else begin
              st_q <= S_WORD;
            end
          end
          S_WORD: st_q <= S_WDATA;
          S_WDATA: begin
            // sequential writes go on without limit until refused
            if (!ackok_q) begin
              st_q <= S_IGNORE;
            end
          end
          default: st_q <= st_q;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_q <= ADDR_RST;
    end else if (byte_done) begin
      if ((st_q == S_ADDR) && hit && byte_in[RW_POS]) begin
        addr_q[ADDR_W-1:BYTE_W] <= byte_in[PAGE_HI:PAGE_LO];
      end else if (st_q == S_WORD) begin
        addr_q <= {page_q, byte_in};
      end else if (wr_commit || rd_inc) begin
        // natural overflow gives the wrap from top to zero
        addr_q <= addr_q + ADDR_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_commit) begin
      mem_q[addr_q] <= byte_in;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oe_n_q <= 1'h1;
      tx_q <= '0;
    end else if (start || stop || !active) begin
      oe_n_q <= 1'h1;
    end else if (ack_beg) begin
      // ackok_q is low in reads, so the line is released for the master
      oe_n_q <= ~ackok_q;
    end else if (ack_end) begin
      if (to_read) begin
        tx_q <= mem_q[addr_q];
        oe_n_q <= mem_q[addr_q][MSB];
      end else begin
        oe_n_q <= 1'h1;
      end
    end else if (scl_fall && (st_q == S_RDATA) && !ackph_q && (cnt_q != CNT_ZERO)) begin
      tx_q <= {tx_q[NXT:0], 1'h0};
      oe_n_q <= tx_q[NXT];
    end
  end

  assign bus.s_sda_o = 1'h0;
  assign bus.s_sda_oe_n = oe_n_q;
  assign cur_addr = addr_q;
  assign selected = active;
endmodule

// File: sim/twnvm_link_props.sv
`timescale 1ns/10ps
module twnvm_link_props #(
  parameter logic [3:0] DEV_TYPE = 4'h6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n
);
  logic scl_q, sda_q, rw_q, ign_q;
  logic [3:0] cnt_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  wire rise = scl & ~scl_q;
  // start or stop: data moves while the clock stays high
  wire cond = scl & scl_q & (sda ^ sda_q);
  wire ack = rise & (cnt_q == 4'h8);
  wire miss = sh_q[7:4] != DEV_TYPE;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt_q <= 4'h0;
    else if (cond) cnt_q <= 4'h0;
    else if (rise) cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) sh_q <= 8'h00;
    else if (rise) sh_q <= {sh_q[6:0], sda};
  end
  // byte index saturates: only address, word address and data are told apart
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byte_q <= 2'h0;
      rw_q <= 1'b0;
      ign_q <= 1'b0;
    end else if (cond) begin
      byte_q <= 2'h0;
      rw_q <= 1'b0;
      ign_q <= 1'b0;
    end else if (ack) begin
      byte_q <= byte_q + {1'b0, byte_q != 2'h3};
      rw_q <= (byte_q == 2'h0) ? sh_q[0] : rw_q;
      ign_q <= ign_q | sda;
    end
  end
  slave_edge_a: assert property ($fell(s_sda_oe_n) |-> !scl)
    else $error("slave pulled data while clock high");
  slave_steady_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe_n))
    else $error("slave data moved while clock high");
  addr_ack_a: assert property (ack && byte_q == 2'h0 && !miss |-> !s_sda_oe_n)
    else $error("matching address not acknowledged");
  type_miss_a: assert property (ack && byte_q == 2'h0 && miss |-> s_sda_oe_n)
    else $error("foreign address acknowledged");
  ignore_hold_a: assert property (ign_q |-> s_sda_oe_n)
    else $error("slave drove after no-acknowledge");
  word_ack_a: assert property (ack && byte_q == 2'h1 && !rw_q && !ign_q |-> !s_sda_oe_n)
    else $error("word address not acknowledged");
  rd_bits_a: assert property (rise && cnt_q != 4'h8 && rw_q && !ign_q && byte_q != 2'h0 |-> m_sda_oe_n)
    else $error("master drove during read data");
  rd_slot_a: assert property (ack && rw_q && byte_q != 2'h0 |-> s_sda_oe_n [*8])
    else $error("slave held data in acknowledge clock");
  wr_slot_a: assert property (ack && !rw_q |-> m_sda_oe_n)
    else $error("master held data in acknowledge clock");
  cover property (ack && rw_q && sda);
  cover property (ack && byte_q == 2'h0 && miss);
  cover property (cond && !sda && byte_q == 2'h2);
endmodule

// File: sim/two_wire_nv_memory_slave_test.sv
`timescale 1ns/10ps
module two_wire_nv_memory_slave_test import twnvm_pkg::*;;
  localparam logic [3:0] DT = 4'h6; // arbitrary device type
  localparam int LIMIT = 95000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [7:0] cmd_byte = 8'h00;
  logic cmd_ready, rsp_valid, rsp_ack, busy, selected;
  logic [7:0] rsp_byte;
  logic [10:0] cur_addr;
  logic [10:0] lat = 11'h000;
  logic [7:0] mem [0:2047];
  logic [2047:0] known = '0;
  // each entry: {compare byte, expected ack, expected byte}
  logic [9:0] expq [$];
  logic [9:0] e;
  logic full_seen = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'h687A;
  always #5 ref_clk = ~ref_clk;
  twnvm_if twnvm_if_i();
  twnvm_master twnvm_master_i(.ref_clk(ref_clk), .rst(rst), .bus(twnvm_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_byte(cmd_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte),
    .rsp_ack(rsp_ack), .busy(busy));
  twnvm_slave #(.DEV_TYPE(DT)) twnvm_slave_i(.ref_clk(ref_clk), .rst(rst), .bus(twnvm_if_i), .wp(wp),
    .cur_addr(cur_addr), .selected(selected));
  twnvm_link_props #(.DEV_TYPE(DT)) twnvm_link_props_i(.ref_clk(ref_clk), .rst(rst), .scl(twnvm_if_i.scl),
    .sda(twnvm_if_i.sda), .m_sda_oe_n(twnvm_if_i.m_sda_oe_n), .s_sda_oe_n(twnvm_if_i.s_sda_oe_n));
  task automatic close_out();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge ref_clk) begin
    if (cmd_ready === 1'b0) full_seen <= 1'b1;
    if (rsp_valid === 1'b1) begin
      e = (expq.size() != 0) ? expq.pop_front() : 10'h3FF;
      chk({2'h0, rsp_ack, rsp_byte & {8{e[9]}}}, {2'h0, e[8], e[7:0] & {8{e[9]}}});
    end
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      close_out();
    end
  end
  task automatic push(input logic [1:0] op, input logic [7:0] b);
    cmd_op <= op;
    cmd_byte <= b;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic byte_out(input logic [1:0] op, input logic [7:0] b, input logic [9:0] ex);
    expq.push_back(ex);
    push(op, b);
  endtask
  // the stop itself lasts 100 cycles once popped
  task automatic settle();
    while (expq.size() != 0) @(posedge ref_clk);
    repeat (130) @(posedge ref_clk);
    chk({9'h000, busy, selected}, 11'h000);
    chk(cur_addr, lat);
  endtask
  // expected read response: byte compared only where the model knows it
  function automatic logic [9:0] rd_exp(input logic [10:0] a, input logic last);
    return {known[a], ~last, mem[a]};
  endfunction
  task automatic wr(input logic [2:0] pg, input logic [7:0] lo, input int n, input logic [3:0] ty);
    logic [7:0] d;
    logic ok;
    ok = (ty == DT);
    push(OP_START, 8'h00);
    byte_out(OP_WRITE, {ty, pg, 1'b0}, {1'b1, ok, ty, pg, 1'b0});
    if (ok) lat = {pg, lo};
    byte_out(OP_WRITE, lo, {1'b1, ok, lo});
    ok = ok & ~wp;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      byte_out(OP_WRITE, d, {1'b1, ok, d});
      if (ok) begin
        mem[lat] = d;
        known[lat] = 1'b1;
        lat = lat + 11'h001;
      end
    end
    push(OP_STOP, 8'h00);
    settle();
  endtask
  task automatic rd(input logic [2:0] pg, input logic sel, input logic [7:0] lo, input int n);
    push(OP_START, 8'h00);
    if (sel) begin
      byte_out(OP_WRITE, {DT, pg, 1'b0}, {2'b11, DT, pg, 1'b0});
      byte_out(OP_WRITE, lo, {2'b11, lo});
      push(OP_START, 8'h00);
      lat = {pg, lo};
    end
    lat = {pg, lat[7:0]};
    byte_out(OP_WRITE, {DT, pg, 1'b1}, {2'b11, DT, pg, 1'b1});
    for (int i = 0; i < n; i++) begin
      byte_out(OP_READ, {7'h00, i == n - 1}, rd_exp(lat, i == n - 1));
      lat = lat + 11'h001;
    end
    push(OP_STOP, 8'h00);
    settle();
  endtask
  initial begin
    logic [2:0] rpg;
    logic [7:0] rlo;
    int rn;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk(cur_addr, 11'h000);
    wr(3'h2, 8'h10, 9, DT);
    rd(3'h2, 1'b1, 8'h10, 9);
    wr(3'h7, 8'hFF, 2, DT);
    rd(3'h7, 1'b1, 8'hFF, 2);
    wp <= 1'b1;
    @(posedge ref_clk);
    wr(3'h2, 8'h12, 2, DT);
    wp <= 1'b0;
    @(posedge ref_clk);
    rd(3'h2, 1'b0, 8'h00, 2);
    wr(3'h1, 8'h40, 1, ~DT);
    // random writes are read back selectively: an unwritten byte has no defined value to put on the line
    for (int k = 0; k < 3; k++) begin
      rpg = 3'($random(seed));
      rlo = 8'($random(seed));
      rn = 1 + ($random(seed) & 3);
      wr(rpg, rlo, rn, DT);
      rd(rpg, 1'b1, rlo, rn);
    end
    chk({10'h000, full_seen}, 11'h001);
    close_out();
  end
endmodule
